// ===== core/host_bus_port.sv
/*
 * Host bus slave port in the 16-bit generic second mode, with strap latch,
 * byte steering, arbitration against display refresh and stall generation.
 * Assumes the back end answers each acc_req_o with one acc_ack_i pulse, and
 * that all pins are asynchronous to sys_clk_i.
 */
`timescale 1ns/1ns
// What this block does
// R01 - Processor drives select low for device region
// R02 - Processor lowers read or write strobe
// R03 - High-byte enable low means sixteen-bit transfer
// R04 - Processor reserves region with select and ready
// R05 - Select, shared high strobe, separate low strobes
// R06 - Latch straps at reset release, then serve
// R07 - Address and data pins connect directly
// R08 - Endian strap orders bytes, little endian here
// R09 - Select asserted for every device access
// R10 - Memory/register input steers buffer or registers
// R11 - High strobe with address bit 0 picks lanes
// R12 - Processor holds write strobe during write
// R13 - Processor holds read strobe during read
// R14 - Stall until read valid or write accepted
// R15 - Arbitrate against refresh, stall until granted
// R16 - Ignore bus-start and direction inputs
// R17 - Bus and memory clocks derive from host clock
// R18 - Stall polarity strap: one high, zero low
// R19 - Clock divide strap: high 2:1, low 1:1
// R20 - Select low registers, high display buffer
// R21 - Data valid before stall release, float after; here read data drives on the same sys_clk_i edge that releases stall
module host_bus_port (
   input  wire logic                                 sys_clk_i,
   input  wire logic                                 sys_rst_i,
   input  wire logic                                 host_clock_in,
   input  wire logic                                 chip_select_in_n,
   input  wire logic                                 mem_reg_select_in,
   input  wire logic [host_port_pkg::ADDR_W-1:0]     host_address_in,
   input  wire logic [host_port_pkg::DATA_W-1:0]     host_data_i,
   output logic      [host_port_pkg::DATA_W-1:0]     host_data_o,
   output logic                                      host_data_oe_o,
   input  wire logic                                 high_byte_strobe_n,
   input  wire logic                                 low_byte_write_strobe_n,
   input  wire logic                                 read_strobe_in_n,
   input  wire logic                                 bus_start_in_n,
   input  wire logic                                 read_write_in_n,
   output logic                                      stall_pin_o,
   input  wire logic                                 endian_strap,
   input  wire logic                                 stall_polarity_strap,
   input  wire logic                                 clock_divide_strap,
   output logic                                      bus_clk_o,
   output logic                                      mem_clk_o,
   output logic                                      port_ready_o,
   input  wire logic                                 refresh_req_i,
   output logic                                      acc_req_o,
   output host_port_pkg::access_cmd_type             acc_cmd_o,
   input  wire logic                                 acc_ack_i,
   input  wire logic [host_port_pkg::DATA_W-1:0]     acc_rdata_i
);

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   // Bus-start and direction pins are left unread in this mode. [R16]
   logic [host_port_pkg::SYNC_W-1:0] pins_s;
   logic                             hc_s;
   logic                             cs_s_n;
   logic                             rd_s_n;
   logic                             we0_s_n;
   logic                             we1_s_n;
   logic                             mr_s;
   logic [host_port_pkg::ADDR_W-1:0] addr_s;
   logic [host_port_pkg::DATA_W-1:0] data_s;
   logic [2:0]                       strap_s;

   pin_sync #(.W(host_port_pkg::SYNC_W), .RST_VAL('1)) u_sync (
      .sys_clk_i (sys_clk_i),
      .sys_rst_i (sys_rst_i),
      .pins_i    ({host_clock_in, chip_select_in_n, read_strobe_in_n,
                   low_byte_write_strobe_n, high_byte_strobe_n, mem_reg_select_in,
                   host_address_in, host_data_i,                        // [R07]
                   endian_strap, stall_polarity_strap, clock_divide_strap}),
      .sync_o    (pins_s)
   );

   assign {hc_s, cs_s_n, rd_s_n, we0_s_n, we1_s_n, mr_s, addr_s, data_s, strap_s} = pins_s;

   function automatic logic [host_port_pkg::DATA_W-1:0] lane_swap(
      input logic [host_port_pkg::DATA_W-1:0] d, input logic big);
      lane_swap = big ? {d[7:0], d[15:8]} : d;
   endfunction : lane_swap

   // -----------------------------------------------------------------
   // Strap latch and clock derivation
   // -----------------------------------------------------------------
   logic [1:0] wait_cnt_r, wait_cnt_nxt;
   logic       latched_r, latched_nxt;
   logic       big_r, big_nxt;
   logic       pol_r, pol_nxt;
   logic       div_r, div_nxt;
   logic       hc_d_r, hc_d_nxt;
   logic       bus_clk_nxt;
   logic       hc_rise;

   always_comb begin
      wait_cnt_nxt = wait_cnt_r;
      latched_nxt  = latched_r;
      big_nxt      = big_r;
      pol_nxt      = pol_r;
      div_nxt      = div_r;
      hc_d_nxt     = hc_s;
      hc_rise      = hc_s & ~hc_d_r;
      // Waiting out the synchroniser keeps the reset value of its flops
      // from being taken for a strap level.
      if (!latched_r) begin
         if (wait_cnt_r == host_port_pkg::STRAP_WAIT) begin
            latched_nxt = 1'h1;                                           // [R06]
            big_nxt     = (strap_s[2] != host_port_pkg::ENDIAN_LITTLE);   // [R08]
            pol_nxt     = strap_s[1];                                     // [R18]
            div_nxt     = strap_s[0];                                     // [R19]
         end else begin
            wait_cnt_nxt = wait_cnt_r + 2'h1;
         end
      end
      if (div_r == host_port_pkg::DIV_TWO_TO_ONE) begin
         bus_clk_nxt = hc_rise ? ~bus_clk_o : bus_clk_o;                  // [R17] [R19]
      end else begin
         bus_clk_nxt = hc_s;                                              // [R17] [R19]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         wait_cnt_r <= 2'h0;
         latched_r  <= 1'h0;
         big_r      <= 1'h0;
         pol_r      <= 1'h0;
         div_r      <= 1'h0;
         hc_d_r     <= 1'h1;
         bus_clk_o  <= 1'h0;
         mem_clk_o  <= 1'h0;
      end else begin
         wait_cnt_r <= wait_cnt_nxt;
         latched_r  <= latched_nxt;
         big_r      <= big_nxt;
         pol_r      <= pol_nxt;
         div_r      <= div_nxt;
         hc_d_r     <= hc_d_nxt;
         bus_clk_o  <= bus_clk_nxt;
         mem_clk_o  <= bus_clk_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Access state machine
   // -----------------------------------------------------------------
   host_port_pkg::port_state_type state_r, state_nxt;
   host_port_pkg::access_cmd_type cmd_nxt;
   logic                          req_nxt;
   logic                          stall_r, stall_nxt;
   logic                          oe_nxt;
   logic                          stall_pin_nxt;
   logic [host_port_pkg::DATA_W-1:0] rdata_nxt;
   logic                          strobe_on;

   always_comb begin
      state_nxt = state_r;
      cmd_nxt   = acc_cmd_o;
      req_nxt   = 1'h0;
      stall_nxt = stall_r;
      rdata_nxt = host_data_o;
      strobe_on = ~cs_s_n & (~rd_s_n | ~we0_s_n);                         // [R05]
      case (state_r)
         host_port_pkg::ST_IDLE: begin
            if (latched_r && strobe_on) begin                             // [R06]
               cmd_nxt.we    = ~we0_s_n;
               cmd_nxt.mem   = (mr_s != host_port_pkg::SEL_REGISTERS);    // [R10] [R20]
               cmd_nxt.addr  = addr_s;
               // High strobe enables the odd lane, address bit 0 gates the even one.
               cmd_nxt.be    = big_r ? {~addr_s[0], ~we1_s_n}             // [R11] [R08]
                                     : {~we1_s_n, ~addr_s[0]};            // [R11]
               cmd_nxt.wdata = lane_swap(data_s, big_r);                  // [R08]
               stall_nxt     = 1'h1;                                      // [R14]
               state_nxt     = host_port_pkg::ST_ARB;
            end
         end
         host_port_pkg::ST_ARB: begin
            if (!refresh_req_i) begin                                     // [R15]
               req_nxt   = 1'h1;
               state_nxt = host_port_pkg::ST_ACCESS;
            end
         end
         host_port_pkg::ST_ACCESS: begin
            if (acc_ack_i) begin
               rdata_nxt = lane_swap(acc_rdata_i, big_r);                 // [R08]
               stall_nxt = 1'h0;                                          // [R14]
               state_nxt = host_port_pkg::ST_HOLD;
            end
         end
         host_port_pkg::ST_HOLD: begin
            if (!strobe_on) begin
               state_nxt = host_port_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = host_port_pkg::ST_IDLE;
            stall_nxt = 1'h0;
         end
      endcase
      // Read data drives only once it is held, and floats with the strobe. [R21]
      oe_nxt = (state_nxt == host_port_pkg::ST_HOLD) && !acc_cmd_o.we;
      stall_pin_nxt = (pol_nxt == host_port_pkg::STALL_ACT_HI) ? stall_nxt : ~stall_nxt; // [R18]
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         state_r        <= host_port_pkg::ST_IDLE;
         acc_cmd_o      <= '0;
         acc_req_o      <= 1'h0;
         stall_r        <= 1'h0;
         host_data_o    <= '0;
         host_data_oe_o <= 1'h0;
         stall_pin_o    <= 1'h0;
         port_ready_o   <= 1'h0;
      end else begin
         state_r        <= state_nxt;
         acc_cmd_o      <= cmd_nxt;
         acc_req_o      <= req_nxt;
         stall_r        <= stall_nxt;
         host_data_o    <= rdata_nxt;
         host_data_oe_o <= oe_nxt;
         stall_pin_o    <= stall_pin_nxt;                                 // [R18]
         port_ready_o   <= latched_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   chk_stall_held: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R14]
      (state_r == host_port_pkg::ST_ARB || state_r == host_port_pkg::ST_ACCESS) |-> stall_r)
      else $error("stall dropped before the access finished");

   chk_refresh_wins: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R15]
      (state_r == host_port_pkg::ST_ARB && refresh_req_i) |=> !acc_req_o && stall_r)
      else $error("host access issued during refresh");

   chk_data_first: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R21]
      ($fell(stall_r) && !acc_cmd_o.we) |-> host_data_oe_o)
      else $error("stall released before read data was driven");

   chk_float_after: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R21]
      (state_r == host_port_pkg::ST_HOLD && cs_s_n) |=> !host_data_oe_o)
      else $error("data bus still driven after select went away");

   chk_latch_first: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R06]
      !latched_r |-> state_r == host_port_pkg::ST_IDLE && !host_data_oe_o)
      else $error("access served before straps were latched");

   chk_idle_level: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R18]
      ($past(latched_r) && state_r == host_port_pkg::ST_IDLE && !$past(stall_r))
      |-> stall_pin_o == !pol_r)
      else $error("idle stall pin level wrong for strap polarity");

   chk_req_once: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R15]
      acc_req_o |=> !acc_req_o ##0 state_r == host_port_pkg::ST_ACCESS)
      else $error("back-end request not a single pulse");

   chk_one_to_one: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R19]
      (latched_r && div_r != host_port_pkg::DIV_TWO_TO_ONE && $rose(hc_s)) |=> bus_clk_o)
      else $error("bus clock did not follow host clock at 1:1");

   chk_two_to_one: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R19]
      (latched_r && div_r == host_port_pkg::DIV_TWO_TO_ONE && hc_s && !hc_d_r)
      |=> bus_clk_o != $past(bus_clk_o))
      else $error("bus clock did not toggle at 2:1");

   chk_lane_pick: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R11]
      (acc_req_o && !big_r) |-> acc_cmd_o.be != 2'h0 || acc_cmd_o.addr[0])
      else $error("no byte lane selected for an even access");

endmodule : host_bus_port

// ===== common/host_port_pkg.sv
/*
 * Shared constants and types for the 16-bit generic host bus port.
 * Assumes it is compiled before every design file that uses it.
 */
package host_port_pkg;

   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int BE_W   = 2;

   // -----------------------------------------------------------------
   // Strap encodings
   // -----------------------------------------------------------------
   localparam logic ENDIAN_LITTLE = 1'h0;
   localparam logic STALL_ACT_HI  = 1'h1;
   localparam logic DIV_TWO_TO_ONE = 1'h1;
   localparam logic SEL_REGISTERS = 1'h0;

   // -----------------------------------------------------------------
   // Pin synchroniser layout and reset wait
   // -----------------------------------------------------------------
   localparam int SYNC_W         = 43;
   localparam logic [1:0] STRAP_WAIT = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_ARB    = 2'b01,
      ST_ACCESS = 2'b10,
      ST_HOLD   = 2'b11
   } port_state_type;

   typedef struct packed {
      logic              we;
      logic              mem;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [BE_W-1:0]   be;
   } access_cmd_type;

endpackage : host_port_pkg

// ===== core/pin_sync.sv
/*
 * Two-flop synchroniser for a vector of asynchronous pins.
 * Assumes the reader only looks at the second stage.
 */
`timescale 1ns/1ns
module pin_sync #(
   parameter int         W       = 8,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input  wire logic         sys_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] pins_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_nxt;

   always_comb begin
      meta_nxt = pins_i;
      sync_nxt = meta_r;
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         meta_r <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta_r <= meta_nxt;
         sync_o <= sync_nxt;
      end
   end

endmodule : pin_sync

// ===== tb/cpu_bus_model.sv
/*
 * Processor side of the 16-bit generic host bus: select, strobes, address, data.
 * Assumes the bench gives the stall level that means wait, and calls access().
 */
`timescale 1ns/1ns
module cpu_bus_model (
   input  wire logic                             sys_clk_i,
   input  wire logic                             stall_pin_i,
   input  wire logic                             stall_act_i,
   input  wire logic [host_port_pkg::DATA_W-1:0] dev_data_i,
   input  wire logic                             dev_oe_i,
   output logic                                  cs_n_o,
   output logic                                  rd_n_o,
   output logic                                  wr_n_o,
   output logic                                  shb_n_o,
   output logic                                  mem_o,
   output logic [host_port_pkg::ADDR_W-1:0]      addr_o,
   output logic [host_port_pkg::DATA_W-1:0]      bus_o
);
   logic                             drv = 1'b0;
   logic [host_port_pkg::DATA_W-1:0] cpu_d = 16'h0000;
   logic [host_port_pkg::DATA_W-1:0] last_r = 16'h0000;
   initial begin
      {cs_n_o, rd_n_o, wr_n_o, shb_n_o, mem_o} = 5'h1f;
      addr_o = 18'h00000;
   end
   // A released bus shows the inverse of its last level so no stale value passes.
   assign bus_o = dev_oe_i ? dev_data_i : (drv ? cpu_d : ~last_r);
   always @(posedge sys_clk_i) last_r <= bus_o;
   // -----------------------------------------------------------------
   // One bus cycle, held until the wait is seen released
   // -----------------------------------------------------------------
   task automatic access(input logic we, input logic m, input logic shb,
                         input logic [17:0] a, input logic [15:0] d,
                         output logic [15:0] q, output logic ok);
      int n;
      @(posedge sys_clk_i);
      addr_o <= a;
      mem_o <= m;
      shb_n_o <= shb;
      cpu_d <= d;
      drv <= we;
      cs_n_o <= 1'b0;
      rd_n_o <= we;
      wr_n_o <= !we;
      n = 0;
      do begin @(posedge sys_clk_i); n++; end while (stall_pin_i !== stall_act_i && n < 20);
      ok = (n < 20);
      n = 0;
      do begin @(posedge sys_clk_i); n++; end while (stall_pin_i === stall_act_i && n < 300);
      q = bus_o;
      ok = ok && (n < 300);
      cs_n_o <= 1'b1;
      rd_n_o <= 1'b1;
      wr_n_o <= 1'b1;
      drv <= 1'b0;
   endtask : access
endmodule : cpu_bus_model

// ===== tb/generic_async_host_bus_port_tb.sv
/*
 * Self-checking bench: processor model in front, back end model with a command queue behind.
 * Assumes host_bus_port and cpu_bus_model are compiled first.
 */
`timescale 1ns/1ns
module generic_async_host_bus_port_tb;
   logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, hclk = 1'b0, refresh = 1'b0;
   logic bs_n = 1'b1, rw_n = 1'b1, pol = 1'b1, div = 1'b0, ack = 1'b0, bclk_q = 1'b0;
   logic cs_n, rd_n, wr_n, shb_n, mem, oe, stall, bclk, mclk, ready, req, ok;
   logic [17:0] addr;
   logic [15:0] bus_d, dout, rdat = 16'h0000, q, d;
   host_port_pkg::access_cmd_type cmd, c;
   host_port_pkg::access_cmd_type cmd_q[$];
   int n_fail = 0, n_tests = 0, cyc = 0, wait_c = 0, n_req = 0, n_bus = 0, hc = 0;
   always #25 sys_clk_i = ~sys_clk_i;
   cpu_bus_model cpu_bus_model_inst (.sys_clk_i(sys_clk_i), .stall_pin_i(stall),
      .stall_act_i(pol), .dev_data_i(dout), .dev_oe_i(oe), .cs_n_o(cs_n), .rd_n_o(rd_n),
      .wr_n_o(wr_n), .shb_n_o(shb_n), .mem_o(mem), .addr_o(addr), .bus_o(bus_d));
   host_bus_port host_bus_port_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .host_clock_in(hclk), .chip_select_in_n(cs_n), .mem_reg_select_in(mem),
      .host_address_in(addr), .host_data_i(bus_d), .host_data_o(dout), .host_data_oe_o(oe),
      .high_byte_strobe_n(shb_n), .low_byte_write_strobe_n(wr_n), .read_strobe_in_n(rd_n),
      .bus_start_in_n(bs_n), .read_write_in_n(rw_n), .stall_pin_o(stall),
      .endian_strap(host_port_pkg::ENDIAN_LITTLE), .stall_polarity_strap(pol),
      .clock_divide_strap(div), .bus_clk_o(bclk), .mem_clk_o(mclk), .port_ready_o(ready),
      .refresh_req_i(refresh), .acc_req_o(req), .acc_cmd_o(cmd), .acc_ack_i(ack),
      .acc_rdata_i(rdat));
   // -----------------------------------------------------------------
   // Back end, host clock and unused pins
   // -----------------------------------------------------------------
   always @(posedge sys_clk_i) begin
      ack <= 1'b0;
      hc <= hc + 1;
      if (hc % 4 == 3) hclk <= ~hclk;
      bclk_q <= bclk;
      if (bclk === 1'b1 && bclk_q === 1'b0) n_bus <= n_bus + 1;
      bs_n <= 1'($urandom);
      rw_n <= 1'($urandom);
      if (req === 1'b1) begin
         cmd_q.push_back(cmd);
         n_req <= n_req + 1;
         wait_c <= $urandom_range(1, 6);
      end else if (wait_c == 1) begin
         ack <= 1'b1;
         wait_c <= 0;
      end else if (wait_c > 1) wait_c <= wait_c - 1;
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         give_verdict();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   // -----------------------------------------------------------------
   // One access, checked against the command and data models
   // -----------------------------------------------------------------
   task automatic one(input logic we, input logic m, input logic shb, input logic [17:0] a);
      d = 16'($urandom);
      rdat <= 16'($urandom);
      cpu_bus_model_inst.access(we, m, shb, a, d, q, ok);
      check("stall_cycle", ok, 1'b1);
      check("req_count", cmd_q.size(), 1);
      c = (cmd_q.size() > 0) ? cmd_q.pop_front() : '0;
      check("cmd_we", c.we, we);
      check("cmd_mem", c.mem, m);
      check("cmd_addr", c.addr, a);
      check("cmd_be", c.be, {~shb, ~a[0]});
      if (we) check("cmd_wdata", c.wdata, d);
      else check("rdata", q, rdat);
      repeat (6) @(posedge sys_clk_i);
      check("oe_off", oe, 1'b0);
   endtask : one
   task automatic run_cfg(input logic p, input logic v);
      int n, b0;
      sys_rst_i <= 1'b1;
      pol <= p;
      div <= v;
      repeat (5) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      n = 0;
      while (ready !== 1'b1 && n < 20) begin @(posedge sys_clk_i); n++; end
      check("ready", ready, 1'b1);
      @(posedge sys_clk_i);
      check("stall_idle", stall, !p);
      b0 = n_bus;
      repeat (160) @(posedge sys_clk_i);
      n = n_bus - b0;
      check("bus_clk", (n >= (v ? 9 : 19)) && (n <= (v ? 11 : 21)), 1);
      check("mem_clk", mclk, bclk);
      for (int i = 0; i < 16; i++) begin
         one(1'($urandom), 1'($urandom), 1'($urandom), 18'($urandom));
      end
      refresh <= 1'b1;
      n = n_req;
      fork
         one(1'b0, 1'b1, 1'b0, 18'h2a5a4);
         begin
            repeat (20) @(posedge sys_clk_i);
            check("refresh_hold", n_req - n, 0);
            check("refresh_stall", stall, p);
            refresh <= 1'b0;
         end
      join
   endtask : run_cfg
   initial begin
      void'($urandom(32'h1d09));
      run_cfg(1'b1, 1'b0);
      run_cfg(1'b0, 1'b1);
      give_verdict();
   end
endmodule : generic_async_host_bus_port_tb
